// *** core/adcrd_pkg.sv ***
/*
 * Shared constants of the converter readout controller: result width,
 * conversion timing in crystal ticks, settling, and reset values.
 * Assumes a 32.768 kHz crystal and a 250 MHz system clock.
 */
`default_nettype none

package adcrd_pkg;
   localparam int XTAL_HZ = 32768;
   localparam int SYS_CLK_HZ = 250000000;
   // Conversion period is 69 x 8 x 3 crystal periods
   localparam int DEC_A = 69;
   localparam int DEC_B = 8;
   localparam int DEC_C = 3;
   localparam int CONV_TICKS = DEC_A * DEC_B * DEC_C;
   localparam int TCNT_W = 11;
   localparam int ACC_W = 11;
   localparam int SUM_W = 12;
   localparam int SETTLE_PERIODS = 2;
   // Crystal ticks spent waiting for PLL lock after select
   localparam int LOCK_TICKS = 64;
   localparam int LOCK_W = 8;
   // Ready goes high this many crystal ticks ahead of an update
   localparam int GUARD_TICKS = 2;
   localparam int RESULT_BITS = 24;
   localparam int IDX_W = 5;
   localparam logic [23:0] WORD_RST = 24'h000000;
   localparam logic [3:0] PIN_RST = 4'h1;
endpackage : adcrd_pkg

`default_nettype wire

// *** core/adcrd_link_if.sv ***
/*
 * Carrier between the system-clock controller and the serial-clock
 * shifter. Assumes word is held stable while clr is low.
 */
`default_nettype none

interface adcrd_link_if;
   logic [23:0] word;
   logic clr;
   logic bit_out;
   logic done;
   modport ctrl (output word, output clr, input bit_out, input done);
   modport link (input word, input clr, output bit_out, output done);
endinterface : adcrd_link_if

`default_nettype wire

// *** core/adcrd_link_shift.sv ***
/*
 * Slave-mode shifter clocked by the host serial clock.
 * Assumes clr is held high whenever no result is pending; the host clock
 * idles high and only starts after ready is seen low, so release of clr is safe.
 */
`default_nettype none

module adcrd_link_shift (
   input wire logic sclk, // host serial clock
   adcrd_link_if.link lk // word, clear and results
);
   logic [4:0] cnt_reg;
   logic bit_reg;
   logic done_reg;

   ////////////////////////////////////////////////////////////////////////
   // Clock may stop at any time, so clr is an async clear to constants
   always_ff @(negedge sclk or posedge lk.clr) begin
      if (lk.clr) begin
         cnt_reg <= 5'h00;
         bit_reg <= 1'b0;
      end else if (cnt_reg < 5'(adcrd_pkg::RESULT_BITS)) begin
         cnt_reg <= cnt_reg + 5'h01;
         bit_reg <= lk.word[5'(adcrd_pkg::RESULT_BITS - 1) - cnt_reg];
      end
   end

   always_ff @(posedge sclk or posedge lk.clr) begin
      if (lk.clr) begin
         done_reg <= 1'b0;
      end else if (cnt_reg == 5'(adcrd_pkg::RESULT_BITS)) begin
         done_reg <= 1'b1;
      end
   end

   assign lk.bit_out = bit_reg;
   assign lk.done = done_reg;

   ////////////////////////////////////////////////////////////////////////
   property p_lk_done;
      @(posedge sclk) disable iff (lk.clr) done_reg |-> cnt_reg == 5'd24;
   endproperty
   a_lk_done: assert property (p_lk_done) else $error("link done before 24 bits");

   property p_lk_cnt;
      @(negedge sclk) disable iff (lk.clr) cnt_reg <= 5'd24;
   endproperty
   a_lk_cnt: assert property (p_lk_cnt) else $error("link shifted past 24 bits");
endmodule : adcrd_link_shift

`default_nettype wire

// *** core/adcrd_ctrl.sv ***
/*
 * Control and serial readout of a single-channel sigma-delta converter:
 * select, PLL lock wait, conversion timing, decimation, ready/data pin,
 * master clock generation and slave shifting.
 * Assumes pins are asynchronous to sys_clk and the crystal is far slower.
 */
// Function
// - Select low powers up, waits PLL lock, then converts continuously.
// - Select high aborts, floats data and clock, standby, drops result.
// - Ready output stays high while a conversion runs.
// - Ready goes low when a result completes.
// - Unread result: ready goes high before the next update.
// - Master holds ready low half a clock period before clocking data.
// - Data changes after falling clock edge, sampled on rising edge.
// - Mode input low selects master, high selects slave.
// - One result every 69 x 8 x 3 crystal periods.
// - First settled result only after two conversion periods.
// - Decimation filter rejects 50 Hz and 60 Hz together.
// - Master sends exactly 24 clocks per result, then idles high.
// - Master clock period equals one crystal period.
// - After a full read ready returns high until the next result.
`default_nettype none

module adcrd_ctrl #(
   parameter int CONV_TICKS = adcrd_pkg::CONV_TICKS,
   parameter int LOCK_TICKS = adcrd_pkg::LOCK_TICKS,
   parameter int GUARD_TICKS = adcrd_pkg::GUARD_TICKS
) (
   input wire logic sys_clk, // system clock
   input wire logic srst, // synchronous reset, high
   input wire logic cs_n_pin, // chip select, low active
   input wire logic mode_pin, // low master, high slave
   input wire logic crystal_in, // crystal oscillator input
   output logic crystal_out, // crystal inverter output
   input wire logic mod_bit_pin, // modulator bitstream
   input wire logic sclk_i, // serial clock from host
   output logic sclk_o, // serial clock driven out
   output logic sclk_oe, // serial clock enable
   output logic dout_rdy_o, // data and ready level
   output logic dout_rdy_oe // data pin enable
);
   localparam int TW = adcrd_pkg::TCNT_W;
   localparam int LW = adcrd_pkg::LOCK_W;
   localparam int AW = adcrd_pkg::ACC_W;
   localparam int SW = adcrd_pkg::SUM_W;
   localparam int IW = adcrd_pkg::IDX_W;
   localparam int NB = adcrd_pkg::RESULT_BITS;

   typedef enum logic [1:0] {ST_STANDBY, ST_LOCK, ST_CONV} adcrd_state_t;

   adcrd_state_t state_reg;
   logic [3:0] pin_s1_reg;
   logic [3:0] pin_s2_reg;
   logic xtal_d_reg;
   logic xout_reg;
   logic [LW-1:0] lock_cnt_reg;
   logic [TW-1:0] tcnt_reg;
   logic [AW-1:0] ones_reg;
   logic [AW-1:0] prev_reg;
   logic [1:0] settle_reg;
   logic [23:0] word_reg;
   logic pending_reg;
   logic sclk_o_reg;
   logic [IW-1:0] m_idx_reg;
   logic m_shift_reg;
   logic m_bit_reg;
   logic clr_reg;
   logic done_s1_reg;
   logic done_s2_reg;
   logic cs_off;
   logic master;
   logic xrise;
   logic xfall;
   logic running;
   logic upd_evt;
   logic guard_evt;
   logic settled_upd;
   logic m_done;
   logic s_done;
   logic [AW-1:0] cur_total;
   logic [SW-1:0] sum_next;

   adcrd_link_if lk ();

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: [0] select, [1] mode, [2] crystal, [3] modulator
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_s1_reg <= adcrd_pkg::PIN_RST;
         pin_s2_reg <= adcrd_pkg::PIN_RST;
         xtal_d_reg <= 1'b0;
      end else begin
         pin_s1_reg <= {mod_bit_pin, crystal_in, mode_pin, cs_n_pin};
         pin_s2_reg <= pin_s1_reg;
         xtal_d_reg <= pin_s2_reg[2];
      end
   end

   assign cs_off = pin_s2_reg[0];
   assign master = ~pin_s2_reg[1];
   assign xrise = pin_s2_reg[2] & ~xtal_d_reg;
   assign xfall = ~pin_s2_reg[2] & xtal_d_reg;
   assign running = (state_reg == ST_CONV) && !cs_off;

   // Oscillator loop closed through a flop; only the phase lag differs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         xout_reg <= 1'b1;
      end else begin
         xout_reg <= ~pin_s2_reg[2];
      end
   end
   assign crystal_out = xout_reg;

   ////////////////////////////////////////////////////////////////////////
   // Power state
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_reg <= ST_STANDBY;
      end else if (cs_off) begin
         state_reg <= ST_STANDBY;
      end else begin
         unique case (state_reg)
            ST_STANDBY: state_reg <= ST_LOCK;
            ST_LOCK: begin
               if (xrise && lock_cnt_reg == LW'(LOCK_TICKS - 1)) begin
                  state_reg <= ST_CONV;
               end
            end
            ST_CONV: state_reg <= ST_CONV;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst || state_reg != ST_LOCK) begin
         lock_cnt_reg <= '0;
      end else if (xrise) begin
         lock_cnt_reg <= lock_cnt_reg + LW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion timing in crystal ticks
   always_ff @(posedge sys_clk) begin
      if (srst || !running) begin
         tcnt_reg <= '0;
      end else if (xrise) begin
         if (tcnt_reg == TW'(CONV_TICKS - 1)) begin
            tcnt_reg <= '0;
         end else begin
            tcnt_reg <= tcnt_reg + TW'(1);
         end
      end
   end

   assign upd_evt = running && xrise && tcnt_reg == TW'(CONV_TICKS - 1);
   assign guard_evt = running && xrise && tcnt_reg == TW'(CONV_TICKS - 1 - GUARD_TICKS);
   assign settled_upd = upd_evt && settle_reg >= 2'(adcrd_pkg::SETTLE_PERIODS - 1);

   ////////////////////////////////////////////////////////////////////////
   // Decimation: two back-to-back boxcar windows summed. The combined
   // window spans two output periods, so its comb of nulls falls close to
   // both mains frequencies; exact placement is a trade against latency.
   assign cur_total = ones_reg + AW'(pin_s2_reg[3]);
   assign sum_next = SW'(prev_reg) + SW'(cur_total);

   always_ff @(posedge sys_clk) begin
      if (srst || !running) begin
         ones_reg <= '0;
         prev_reg <= '0;
         settle_reg <= 2'h0;
      end else if (upd_evt) begin
         ones_reg <= '0;
         prev_reg <= cur_total;
         if (settle_reg < 2'(adcrd_pkg::SETTLE_PERIODS)) begin
            settle_reg <= settle_reg + 2'h1;
         end
      end else if (xrise) begin
         ones_reg <= cur_total;
      end
   end

   // Result is discarded when deselected
   always_ff @(posedge sys_clk) begin
      if (srst || cs_off) begin
         word_reg <= adcrd_pkg::WORD_RST;
      end else if (settled_upd) begin
         word_reg <= {sum_next, 12'h000};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending result; a new result wins over a read finishing the same cycle
   // Read ends the cycle after the last rise, so the final bit holds across that edge
   assign m_done = master && pending_reg && sclk_o_reg && m_idx_reg == IW'(NB);
   assign s_done = !master && pending_reg && done_s2_reg;

   always_ff @(posedge sys_clk) begin
      if (srst || cs_off) begin
         pending_reg <= 1'b0;
      end else if (settled_upd) begin
         pending_reg <= 1'b1;
      end else if (guard_evt || !running) begin
         pending_reg <= 1'b0;
      end else if (m_done || s_done) begin
         pending_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Master clock: first fall comes half a crystal period after ready
   always_ff @(posedge sys_clk) begin
      if (srst || !pending_reg || !master) begin
         sclk_o_reg <= 1'b1;
         m_idx_reg <= '0;
         m_shift_reg <= 1'b0;
      end else begin
         m_shift_reg <= 1'b0;
         if (xfall && m_idx_reg < IW'(NB)) begin
            sclk_o_reg <= 1'b0;
            m_idx_reg <= m_idx_reg + IW'(1);
            m_shift_reg <= 1'b1;
         end else if (xrise) begin
            sclk_o_reg <= 1'b1;
         end
      end
   end

   // Bit moves the cycle after the clock fell
   always_ff @(posedge sys_clk) begin
      if (srst || !pending_reg || !master) begin
         m_bit_reg <= 1'b0;
      end else if (m_shift_reg) begin
         m_bit_reg <= word_reg[IW'(NB) - m_idx_reg];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slave path: shifter on the host clock, held cleared while idle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         clr_reg <= 1'b1;
      end else begin
         clr_reg <= !pending_reg || master;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
      end else begin
         done_s1_reg <= lk.done;
         done_s2_reg <= done_s1_reg;
      end
   end

   assign lk.word = word_reg;
   assign lk.clr = clr_reg;

   adcrd_link_shift u_shift (
      .sclk (sclk_i),
      .lk (lk.link)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pins
   always_comb begin
      if (!pending_reg) begin
         dout_rdy_o = 1'b1;
      end else if (master) begin
         dout_rdy_o = m_bit_reg;
      end else begin
         dout_rdy_o = lk.bit_out;
      end
   end

   assign dout_rdy_oe = (state_reg != ST_STANDBY) && !cs_off;
   assign sclk_oe = dout_rdy_oe && master;
   assign sclk_o = sclk_o_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   logic [IW-1:0] fall_cnt_reg;
   always_ff @(posedge sys_clk) begin
      if (srst || !pending_reg) begin
         fall_cnt_reg <= '0;
      end else if (sclk_o_reg && xfall && master && m_idx_reg < IW'(NB)) begin
         fall_cnt_reg <= fall_cnt_reg + IW'(1);
      end
   end

   property p_cs_off;
      cs_off |=> !dout_rdy_oe && !sclk_oe && !pending_reg && word_reg == 24'h000000;
   endproperty
   a_cs_off: assert property (p_cs_off) else $error("select high did not float pins");

   property p_lock;
      $rose(state_reg == ST_LOCK) |-> !running [*8];
   endproperty
   a_lock: assert property (p_lock) else $error("converted before lock wait");

   property p_busy_high;
      running && !pending_reg |-> dout_rdy_o && dout_rdy_oe;
   endproperty
   a_busy_high: assert property (p_busy_high) else $error("ready low during conversion");

   property p_ready_low;
      settled_upd && !cs_off |=> pending_reg && !dout_rdy_o;
   endproperty
   a_ready_low: assert property (p_ready_low) else $error("ready not low on result");

   property p_guard;
      guard_evt && !settled_upd |=> !pending_reg;
   endproperty
   a_guard: assert property (p_guard) else $error("ready still low before update");

   property p_half;
      $rose(pending_reg) && master |-> sclk_o_reg [*8];
   endproperty
   a_half: assert property (p_half) else $error("clock started too early");

   property p_bit_after_fall;
      master && pending_reg && $changed(m_bit_reg) |-> $past(sclk_o_reg) == 1'b0 && $past(sclk_o_reg, 2) == 1'b1;
   endproperty
   a_bit_after_fall: assert property (p_bit_after_fall) else $error("data moved off falling edge");

   property p_period;
      upd_evt |=> tcnt_reg == '0;
   endproperty
   a_period: assert property (p_period) else $error("conversion period wrong");

   property p_settle;
      pending_reg |-> settle_reg == 2'd2;
   endproperty
   a_settle: assert property (p_settle) else $error("result before settling");

   property p_24_clocks;
      m_done |-> fall_cnt_reg == 5'd24 ##1 (sclk_o_reg || settled_upd);
   endproperty
   a_24_clocks: assert property (p_24_clocks) else $error("master clock count wrong");

   property p_read_done;
      (m_done || s_done) && !settled_upd |=> !pending_reg && dout_rdy_o;
   endproperty
   a_read_done: assert property (p_read_done) else $error("ready not high after read");

   c_master_read: cover property (m_done);
   c_slave_read: cover property (s_done);
   c_unread_drop: cover property (guard_evt && pending_reg);
   c_abort: cover property (cs_off && pending_reg);
endmodule : adcrd_ctrl

`default_nettype wire

// *** verif/adcrd_host_model.sv ***
/*
 * Host model on the far side of the serial pins: samples data on rising
 * clock edges and, in slave mode, drives the serial clock in batches.
 * Assumes the bench resolves both pins and selects this clock in slave mode.
 */
`default_nettype none

module adcrd_host_model (
   input wire logic sclk_line, // resolved serial clock
   input wire logic dout_line, // resolved data/ready pin
   output logic host_sclk // clock driven by the host
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] word;
   int rises;

   initial host_sclk = 1'b1;

   always @(posedge sclk_line) begin
      word <= {word[22:0], dout_line};
      rises <= rises + 1;
   end

   task clear_count();
      rises = 0;
   endtask : clear_count

   // Clock returns high after every pulse, so a pause is a legal batch split
   task pulse(input int n);
      repeat (n) begin
         #32 host_sclk = 1'b0;
         #32 host_sclk = 1'b1;
      end
   endtask : pulse
endmodule : adcrd_host_model

`default_nettype wire

// *** verif/adc_serial_readout_ctrl_bench.sv ***
/*
 * Self-checking bench of the converter readout controller: master read,
 * abort, slave read in batches, unread result.
 * Assumes shortened conversion counts and a 400 ns crystal period.
 */
`default_nettype none

module adc_serial_readout_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CT = 40;
   localparam int XP = 400;
   localparam logic [11:0] SUM = 12'(2 * CT);
   localparam logic [23:0] EXP = {SUM, 12'h000};
   // Alternating modulator bits fill half of each two-window sum, whatever the phase
   localparam logic [23:0] EXP_HALF = {12'(CT), 12'h000};
   logic sys_clk, srst, cs_n_pin, mode_pin, crystal_in, mod_bit_pin, crystal_out, mod_alt;
   logic sclk_o, sclk_oe, dout_rdy_o, dout_rdy_oe, host_sclk, float_pat;
   logic sclk_line, dout_line;
   int failures, checks_done;
   time t0, t1, t2, d;

   // Undriven pins toggle so a floated line never reads as a stable level
   assign dout_line = dout_rdy_oe ? dout_rdy_o : float_pat;
   assign sclk_line = sclk_oe ? sclk_o : (mode_pin ? host_sclk : float_pat);

   adcrd_ctrl #(.CONV_TICKS(CT), .LOCK_TICKS(4), .GUARD_TICKS(2)) uut (
      .sys_clk(sys_clk), .srst(srst), .cs_n_pin(cs_n_pin), .mode_pin(mode_pin),
      .crystal_in(crystal_in), .crystal_out(crystal_out), .mod_bit_pin(mod_bit_pin),
      .sclk_i(sclk_line), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
      .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe));

   adcrd_host_model host (.sclk_line(sclk_line), .dout_line(dout_line), .host_sclk(host_sclk));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      crystal_in = 1'b0;
      forever #200 crystal_in = ~crystal_in;
   end

   // Modulator changes half a crystal period away from its sampling edge
   always @(negedge crystal_in) begin
      if (mod_alt) begin
         mod_bit_pin <= ~mod_bit_pin;
      end
   end

   initial float_pat = 1'b0;
   always @(posedge sys_clk) float_pat <= ~float_pat;

   ////////////////////////////////////////////////////////////////////////
   task conclude();
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude

   task judge(input bit ok, input logic [31:0] got, input logic [31:0] expv);
      checks_done++;
      if (!ok) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, expv);
      end
   endtask : judge

   task drive_pins(input logic cs, input logic md);
      @(posedge sys_clk);
      #1 cs_n_pin = cs;
      mode_pin = md;
   endtask : drive_pins

   // Sampled on falling edges, where registered outputs have settled
   task wait_dout(input logic v, input int n);
      int i;
      i = 0;
      while (dout_line !== v && i < n) begin
         @(negedge sys_clk);
         i++;
      end
      if (i >= n) begin
         judge(1'b0, {31'h0, dout_line}, {31'h0, v});
      end
   endtask : wait_dout

   ////////////////////////////////////////////////////////////////////////
   task t_master();
      @(posedge crystal_in);
      repeat (5) @(negedge sys_clk);
      judge(crystal_out === ~crystal_in, {31'h0, crystal_out}, {31'h0, ~crystal_in});
      drive_pins(1'b0, 1'b0);
      t0 = $time;
      repeat (5) @(posedge sys_clk);
      wait_dout(1'b0, 12000);
      t1 = $time;
      host.clear_count();
      judge(t1 - t0 >= 2 * CT * XP, 32'(t1 - t0), 32'(2 * CT * XP));
      judge(t1 - t0 <= (2 * CT + 8) * XP, 32'(t1 - t0), 32'((2 * CT + 8) * XP));
      @(negedge sclk_o);
      t2 = $time;
      // t1 lags the fall of ready by half a system clock
      judge(t2 - t1 + 2 >= XP / 2, 32'(t2 - t1 + 2), 32'(XP / 2));
      @(negedge sclk_o);
      judge($time - t2 == XP, 32'($time - t2), 32'(XP));
      judge(sclk_oe === 1'b1, {31'h0, sclk_oe}, 32'h1);
      // Data bits may be high, so the end of the read is found by counting rises
      repeat (23) @(posedge sclk_o);
      repeat (4) @(negedge sys_clk);
      judge(dout_line === 1'b1, {31'h0, dout_line}, 32'h1);
      judge(host.word === EXP, {8'h00, host.word}, {8'h00, EXP});
      judge(host.rises == 24, 32'(host.rises), 32'h18);
      repeat (500) @(negedge sys_clk);
      judge(sclk_o === 1'b1 && dout_line === 1'b1 && host.rises == 24, {sclk_o, dout_line}, 2'b11);
      wait_dout(1'b0, CT * XP / 4);
      d = $time - t1;
      judge(d >= CT * XP - 8 && d <= CT * XP + 8, 32'(d), 32'(CT * XP));
   endtask : t_master

   task t_abort();
      repeat (8) @(negedge sclk_o);
      drive_pins(1'b1, 1'b0);
      repeat (4) @(posedge sys_clk);
      #1;
      judge(dout_rdy_oe === 1'b0 && sclk_oe === 1'b0, {dout_rdy_oe, sclk_oe}, 2'b00);
   endtask : t_abort

   task t_slave();
      mod_alt = 1'b1;
      drive_pins(1'b0, 1'b1);
      t0 = $time;
      host.pulse(6);
      wait_dout(1'b0, 12000);
      t1 = $time;
      judge(t1 - t0 >= 2 * CT * XP, 32'(t1 - t0), 32'(2 * CT * XP));
      repeat (4) @(posedge sys_clk);
      judge(sclk_oe === 1'b0, {31'h0, sclk_oe}, 32'h0);
      host.pulse(8);
      #500;
      host.pulse(8);
      #500;
      host.pulse(8);
      #1;
      judge(host.word === EXP_HALF, {8'h00, host.word}, {8'h00, EXP_HALF});
      repeat (8) @(negedge sys_clk);
      judge(dout_line === 1'b1, {31'h0, dout_line}, 32'h1);
   endtask : t_slave

   task t_unread();
      wait_dout(1'b0, CT * XP / 4 + 100);
      t1 = $time;
      wait_dout(1'b1, CT * XP / 4);
      t2 = $time;
      wait_dout(1'b0, CT * XP / 4);
      judge($time - t2 >= XP, 32'($time - t2), 32'(XP));
      d = $time - t1;
      judge(d >= CT * XP - 8 && d <= CT * XP + 8, 32'(d), 32'(CT * XP));
   endtask : t_unread

   ////////////////////////////////////////////////////////////////////////
   initial begin
      srst = 1'b1;
      cs_n_pin = 1'b1;
      mode_pin = 1'b0;
      mod_bit_pin = 1'b1;
      mod_alt = 1'b0;
      failures = 0;
      checks_done = 0;
      repeat (2) @(posedge sys_clk);
      #1 srst = 1'b0;
      t_master();
      t_abort();
      t_slave();
      t_unread();
      conclude();
   end

   initial begin
      #400000;
      failures++;
      conclude();
   end
endmodule : adc_serial_readout_ctrl_bench

`default_nettype wire
